// [core/dcs_debug_ctrl.sv]
`timescale 1ns/1ps
module dcs_debug_ctrl (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          CMD_VALID,
  input  wire logic [7:0]                    CMD_BYTE,
  output logic                               RSP_VALID,
  output logic [7:0]                         RSP_BYTE,
  input  wire logic                          FETCH_VALID,
  input  wire logic [dcs_pkg::BP_ADDR_W-1:0] FETCH_ADDR,
  input  wire logic                          DATA_WR_EN,
  input  wire logic [7:0]                    DATA_WR_ADDR,
  input  wire logic                          CPU_CLOCK_GATED,
  input  wire dcs_pkg::dcs_pmode_t           POWER_MODE,
  input  wire logic                          CRYSTAL_STABLE_FLAG,
  input  wire logic                          FAST_RC_STABLE_FLAG,
  input  wire logic                          DEBUG_LOCK_FUSE,
  input  wire logic                          ERASE_BUSY,
  input  wire logic                          DEBUG_ACTIVE,
  input  wire logic                          INJECT_EXEC,
  input  wire logic                          STEP_BRANCH,
  output logic                               CPU_HALT,
  output logic                               TIMERS_STOP,
  output logic                               DMA_PAUSE,
  output logic                               INFO_REGION_SELECT,
  output logic                               REGULATOR_HOLD_ON
);

  // ---------------------------------------------------------------
  // command sequencer state
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE     = 5'b00001,
    S_CFG_DATA = 5'b00010,
    S_BP_B1    = 5'b00100,
    S_BP_B2    = 5'b01000,
    S_BP_B3    = 5'b10000
  } dcs_state_t;

  dcs_state_t           state_r;
  dcs_state_t           state_nxt;
  dcs_pkg::dcs_cfg_t    cfg_r;
  dcs_pkg::dcs_bp_ctl_t bp_ctl_r;
  logic [7:0]           bp_mid_r;
  dcs_pkg::dcs_bp_wr_t  bp_wr_r;
  logic                 halted_r;
  logic                 halted_nxt;
  logic                 halt_by_bp_r;
  logic                 halt_by_bp_nxt;
  logic                 stack_ovf_r;
  logic                 skip_r;
  logic                 rsp_valid_r;
  logic [7:0]           rsp_byte_r;
  logic                 timers_stop_r;
  logic                 dma_pause_r;
  logic                 info_sel_r;
  logic                 reg_hold_r;
  logic                 bp_hit;
  logic                 deep_wake;

  function automatic logic is_cmd(input logic valid, input logic [7:0] b, input logic [7:0] code);
    is_cmd = valid && (b == code);
  endfunction

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire in_idle    = (state_r == S_IDLE);
  wire cmd_wr_cfg = in_idle && is_cmd(CMD_VALID, CMD_BYTE, dcs_pkg::CMD_WR_CONFIG);
  wire cmd_rd_cfg = in_idle && is_cmd(CMD_VALID, CMD_BYTE, dcs_pkg::CMD_RD_CONFIG);
  wire cmd_status = in_idle && is_cmd(CMD_VALID, CMD_BYTE, dcs_pkg::CMD_READ_STATUS);
  wire cmd_set_bp = in_idle && is_cmd(CMD_VALID, CMD_BYTE, dcs_pkg::CMD_SET_BP);
  wire cmd_halt   = in_idle && is_cmd(CMD_VALID, CMD_BYTE, dcs_pkg::CMD_HALT);
  wire cmd_resume = in_idle && is_cmd(CMD_VALID, CMD_BYTE, dcs_pkg::CMD_RESUME);
  wire resume_ok  = cmd_resume && halted_r;
  wire cfg_load   = (state_r == S_CFG_DATA) && CMD_VALID;
  wire bp_commit  = (state_r == S_BP_B3) && CMD_VALID;

  // a breakpoint sitting on the resume address would halt again at once,
  // so the first fetch after a resume is not compared
  wire fetch_en   = FETCH_VALID && !halted_r && !skip_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (cmd_wr_cfg) begin
          state_nxt = S_CFG_DATA;
        end else if (cmd_set_bp) begin
          state_nxt = S_BP_B1;
        end
      end
      S_CFG_DATA: begin
        if (CMD_VALID) begin
          state_nxt = S_IDLE;
        end
      end
      S_BP_B1: begin
        if (CMD_VALID) begin
          state_nxt = S_BP_B2;
        end
      end
      S_BP_B2: begin
        if (CMD_VALID) begin
          state_nxt = S_BP_B3;
        end
      end
      S_BP_B3: begin
        if (CMD_VALID) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // configuration byte
  // ---------------------------------------------------------------
  // all eight bits are kept so a read returns exactly what was written;
  // only the low four steer anything, the host keeps the rest zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_r <= dcs_pkg::CFG_RESET;
    end else if (cfg_load) begin
      cfg_r <= CMD_BYTE;
    end
  end

  wire timers_stop_w = cfg_r.timers_off
                     || (cfg_r.timer_suspend && (INJECT_EXEC || STEP_BRANCH));

  always_ff @(posedge CLK) begin
    if (RST) begin
      timers_stop_r <= 1'b0;
      dma_pause_r   <= 1'b0;
      info_sel_r    <= 1'b0;
      reg_hold_r    <= 1'b0;
    end else begin
      timers_stop_r <= timers_stop_w;
      dma_pause_r   <= cfg_r.dma_pause;
      info_sel_r    <= cfg_r.info_region_select;
      reg_hold_r    <= DEBUG_ACTIVE;
    end
  end

  // ---------------------------------------------------------------
  // breakpoint loading
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      bp_ctl_r <= '0;
      bp_mid_r <= 8'h00;
      bp_wr_r  <= '0;
    end else begin
      if ((state_r == S_BP_B1) && CMD_VALID) begin
        bp_ctl_r <= CMD_BYTE;
      end
      if ((state_r == S_BP_B2) && CMD_VALID) begin
        bp_mid_r <= CMD_BYTE;
      end
      bp_wr_r.valid <= bp_commit;
      if (bp_commit) begin
        bp_wr_r.sel  <= bp_ctl_r.sel;
        bp_wr_r.en   <= bp_ctl_r.en;
        bp_wr_r.addr <= {bp_ctl_r.addr_hi, bp_mid_r, CMD_BYTE};
      end
    end
  end

  dcs_bkpt_bank #(
    .NUM (dcs_pkg::BP_NUM),
    .AW  (dcs_pkg::BP_ADDR_W)
  ) u_bkpt (
    .clk        (CLK),
    .rst        (RST),
    .wr         (bp_wr_r),
    .fetch_en   (fetch_en),
    .fetch_addr (FETCH_ADDR),
    .hit_r      (bp_hit)
  );

  dcs_wake_watch u_wake (
    .clk          (CLK),
    .rst          (RST),
    .pmode        (POWER_MODE),
    .debug_active (DEBUG_ACTIVE),
    .deep_wake_r  (deep_wake)
  );

  // ---------------------------------------------------------------
  // halt control
  // ---------------------------------------------------------------
  // a breakpoint beats a halt command in the same cycle; a halt command
  // given while already halted is not a new halt and keeps the cause
  always_comb begin
    halted_nxt     = halted_r;
    halt_by_bp_nxt = halt_by_bp_r;
    if (bp_hit && !halted_r) begin
      halted_nxt     = 1'b1;
      halt_by_bp_nxt = 1'b1;
    end else if ((cmd_halt || deep_wake) && !halted_r) begin
      halted_nxt     = 1'b1;
      halt_by_bp_nxt = 1'b0;
    end else if (resume_ok) begin
      halted_nxt     = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      halted_r     <= 1'b0;
      halt_by_bp_r <= 1'b0;
      skip_r       <= 1'b0;
    end else begin
      halted_r     <= halted_nxt;
      halt_by_bp_r <= halt_by_bp_nxt;
      if (resume_ok) begin
        skip_r <= 1'b1;
      end else if (FETCH_VALID) begin
        skip_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // status byte
  // ---------------------------------------------------------------
  wire stack_hit = DATA_WR_EN && (DATA_WR_ADDR == dcs_pkg::STACK_TOP_ADDR);

  // no clear exists other than reset, so the flag is simply sticky
  always_ff @(posedge CLK) begin
    if (RST) begin
      stack_ovf_r <= 1'b0;
    end else if (stack_hit) begin
      stack_ovf_r <= 1'b1;
    end
  end

  dcs_pkg::dcs_status_t status_w;
  assign status_w.erase_done      = !ERASE_BUSY;
  assign status_w.cpu_clock_gated = CPU_CLOCK_GATED;
  assign status_w.halted          = halted_r;
  assign status_w.active_mode     = (POWER_MODE == dcs_pkg::ACTIVE_POWER_STATE_MODE);
  assign status_w.halt_by_bp      = halt_by_bp_r;
  assign status_w.locked          = DEBUG_LOCK_FUSE;
  assign status_w.osc_stable      = CRYSTAL_STABLE_FLAG && FAST_RC_STABLE_FLAG;
  assign status_w.stack_overflow  = stack_ovf_r;

  // ---------------------------------------------------------------
  // answers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      rsp_valid_r <= 1'b0;
      rsp_byte_r  <= 8'h00;
    end else begin
      rsp_valid_r <= cmd_rd_cfg || cmd_status;
      if (cmd_status) begin
        rsp_byte_r <= status_w;
      end else if (cmd_rd_cfg) begin
        rsp_byte_r <= cfg_r;
      end
    end
  end

  assign RSP_VALID          = rsp_valid_r;
  assign RSP_BYTE           = rsp_byte_r;
  assign CPU_HALT           = halted_r;
  assign TIMERS_STOP        = timers_stop_r;
  assign DMA_PAUSE          = dma_pause_r;
  assign INFO_REGION_SELECT = info_sel_r;
  assign REGULATOR_HOLD_ON  = reg_hold_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // the host may leave idle cycles between bytes, so each step waits a few cycles
  sequence s_wr_cfg;
    cmd_wr_cfg ##[1:8] cfg_load;
  endsequence

  sequence s_set_bp;
    cmd_set_bp ##[2:8] bp_commit;
  endsequence

  a_cfg_store_read: assert property (@(posedge CLK) disable iff (RST)
    s_wr_cfg ##[1:8] cmd_rd_cfg |=> RSP_VALID && (RSP_BYTE == $past(cfg_r)))
    else $error("config read does not return stored value");

  a_cfg_write_lands: assert property (@(posedge CLK) disable iff (RST)
    s_wr_cfg |=> (cfg_r == $past(CMD_BYTE)) && (state_r == S_IDLE))
    else $error("config write not stored");

  a_timers_off_wins: assert property (@(posedge CLK) disable iff (RST)
    cfg_r.timers_off && $stable(cfg_r) |=> TIMERS_STOP)
    else $error("timers not stopped while disabled");

  a_timer_suspend: assert property (@(posedge CLK) disable iff (RST)
    !cfg_r.timers_off && (INJECT_EXEC || STEP_BRANCH) |=> TIMERS_STOP == $past(cfg_r.timer_suspend))
    else $error("timer suspend wrong during debug instruction");

  a_dma_follow: assert property (@(posedge CLK) disable iff (RST)
    $changed(cfg_r.dma_pause) |=> DMA_PAUSE == $past(cfg_r.dma_pause))
    else $error("dma pause does not follow config");

  a_bp_halts: assert property (@(posedge CLK) disable iff (RST)
    s_set_bp ##[2:300] (bp_wr_r.en && fetch_en && (FETCH_ADDR == bp_wr_r.addr))
      |=> ##1 (CPU_HALT && halt_by_bp_r))
    else $error("enabled breakpoint did not halt");

  a_halt_cmd_cause: assert property (@(posedge CLK) disable iff (RST)
    cmd_halt && !halted_r && !bp_hit |=> CPU_HALT && !halt_by_bp_r)
    else $error("halt command cause wrong");

  a_resume_needs_halt: assert property (@(posedge CLK) disable iff (RST)
    cmd_resume && halted_r |=> !CPU_HALT)
    else $error("resume not honoured");

  a_resume_refused: assert property (@(posedge CLK) disable iff (RST)
    cmd_resume && !halted_r && !skip_r |=> !skip_r)
    else $error("resume accepted while running");

  a_stack_sticky: assert property (@(posedge CLK) disable iff (RST)
    stack_hit |=> stack_ovf_r [*4])
    else $error("stack overflow flag not held");

  a_deep_wake_halts: assert property (@(posedge CLK) disable iff (RST)
    deep_wake && !halted_r && !bp_hit |=> CPU_HALT)
    else $error("cpu not stopped after deep wake");

  a_status_answer: assert property (@(posedge CLK) disable iff (RST)
    cmd_status |=> RSP_VALID && (RSP_BYTE[1] == $past(CRYSTAL_STABLE_FLAG && FAST_RC_STABLE_FLAG))
      && (RSP_BYTE[5] == $past(halted_r)))
    else $error("status answer wrong");

  a_regulator_hold: assert property (@(posedge CLK) disable iff (RST)
    DEBUG_ACTIVE [*2] |-> REGULATOR_HOLD_ON)
    else $error("regulator released while debugging");

endmodule

// [pkg/dcs_pkg.sv]
// Behaviour
// - configuration bit 3 stops all timers and overrides timer suspend
// - configuration bit 2 pauses every dma transfer
// - configuration bit 1 stops timer counting during debug instructions and stepped branches
// - configuration bit 0 selects main flash or the 2KB information page
// - status bit 7 reads zero during chip erase, one when done
// - status bit 6 reads one while the cpu clock is gated
// - status bit 5 shows halted; bit 3 shows last halt cause
// - status bit 4 reads one only in the active power mode
// - status bit 2 mirrors the stored debug lock bit
// - status bit 1 is one only when both oscillators are stable
// - status bit 0 sets when the cpu writes data address 0xff
// - four independent breakpoints, each separately enabled or disabled
// - an enabled breakpoint matching the code address halts the cpu; the first fetch after a resume is not compared
// - first byte: bits 4-3 select, bit 2 enable, bits 1-0 address 17-16
// - second byte gives address 15-8, third gives address 7-0
// - while debugging, low-power modes keep the digital regulator on
// - waking from light sleep continues executing without host help
// - configuration written with 0x19, read back with 0x24 as last written
// - status returned for 0x30, breakpoints set with 0x3f
// - halt is 0x44, resume is 0x4c and only accepted while halted
package dcs_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WR_CONFIG   = 8'h19;
  localparam logic [7:0] CMD_RD_CONFIG   = 8'h24;
  localparam logic [7:0] CMD_READ_STATUS = 8'h30;
  localparam logic [7:0] CMD_SET_BP      = 8'h3f;
  localparam logic [7:0] CMD_HALT        = 8'h44;
  localparam logic [7:0] CMD_RESUME      = 8'h4c;

  // ---------------------------------------------------------------
  // sizes and constants
  // ---------------------------------------------------------------
  localparam int         BP_NUM         = 4;
  localparam int         BP_ADDR_W      = 18;
  localparam logic [7:0] STACK_TOP_ADDR = 8'hff;
  localparam logic [7:0] CFG_RESET      = 8'h00;

  typedef enum logic [1:0] {
    ACTIVE_POWER_STATE_MODE = 2'h0,
    LIGHT_SLEEP_MODE        = 2'h1,
    DEEP_SLEEP_MODE         = 2'h2,
    DEEPEST_SLEEP_MODE      = 2'h3
  } dcs_pmode_t;

  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] unused;
    logic       timers_off;
    logic       dma_pause;
    logic       timer_suspend;
    logic       info_region_select;
  } dcs_cfg_t;

  typedef struct packed {
    logic erase_done;
    logic cpu_clock_gated;
    logic halted;
    logic active_mode;
    logic halt_by_bp;
    logic locked;
    logic osc_stable;
    logic stack_overflow;
  } dcs_status_t;

  typedef struct packed {
    logic [2:0] unused;
    logic [1:0] sel;
    logic       en;
    logic [1:0] addr_hi;
  } dcs_bp_ctl_t;

  typedef struct packed {
    logic                 valid;
    logic [1:0]           sel;
    logic                 en;
    logic [BP_ADDR_W-1:0] addr;
  } dcs_bp_wr_t;

endpackage

// [core/dcs_bkpt_bank.sv]
`timescale 1ns/1ps
module dcs_bkpt_bank #(
  parameter int NUM = dcs_pkg::BP_NUM,
  parameter int AW  = dcs_pkg::BP_ADDR_W
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire dcs_pkg::dcs_bp_wr_t wr,
  input  wire logic               fetch_en,
  input  wire logic [AW-1:0]      fetch_addr,
  output logic                    hit_r
);

  // select field is two bits wide, so more than four entries cannot be reached
  if (NUM < 1 || NUM > 4 || AW != dcs_pkg::BP_ADDR_W) begin : g_bad_param
    $error("dcs_bkpt_bank: unsupported parameters");
  end

  logic [NUM-1:0] match_w;

  // ---------------------------------------------------------------
  // entries
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM; i++) begin : g_bp
    logic          en_r;
    logic [AW-1:0] addr_r;
    wire           sel_w = wr.valid && (wr.sel == 2'(i));

    always_ff @(posedge clk) begin
      if (rst) begin
        en_r   <= 1'b0;
        addr_r <= '0;
      end else if (sel_w) begin
        en_r   <= wr.en;
        addr_r <= wr.addr;
      end
    end

    assign match_w[i] = en_r && (addr_r == fetch_addr);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= fetch_en && (|match_w);
    end
  end

endmodule

// [core/dcs_wake_watch.sv]
`timescale 1ns/1ps
module dcs_wake_watch (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire dcs_pkg::dcs_pmode_t pmode,
  input  wire logic               debug_active,
  output logic                    deep_wake_r
);

  dcs_pkg::dcs_pmode_t prev_r;

  // light sleep is left out on purpose: execution carries on by itself
  wire was_deep_w = (prev_r == dcs_pkg::DEEP_SLEEP_MODE) || (prev_r == dcs_pkg::DEEPEST_SLEEP_MODE);
  wire now_act_w  = (pmode == dcs_pkg::ACTIVE_POWER_STATE_MODE);

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r      <= dcs_pkg::ACTIVE_POWER_STATE_MODE;
      deep_wake_r <= 1'b0;
    end else begin
      prev_r      <= pmode;
      deep_wake_r <= debug_active && was_deep_w && now_act_w;
    end
  end

endmodule

// [dv/dcs_host_model.sv]
`timescale 1ns/1ps
module dcs_host_model (
  input  wire logic       clk,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_byte,
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte
);
  initial begin
    cmd_valid = 1'h0;
    cmd_byte  = 8'h00;
  end
  // one idle cycle between bytes; the released byte lines show the inverse so stale data never looks valid
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk);
    cmd_valid = 1'h1;
    cmd_byte  = b;
    @(negedge clk);
    cmd_valid = 1'h0;
    cmd_byte  = ~b;
  endtask
  task automatic write_cfg(input logic [3:0] low);
    send_byte(dcs_pkg::CMD_WR_CONFIG);
    send_byte({4'h0, low});
  endtask
  task automatic set_bp(input logic [1:0] sel, input logic en, input logic [17:0] a);
    dcs_pkg::dcs_bp_ctl_t c;
    c = '{unused: 3'h0, sel: sel, en: en, addr_hi: a[17:16]};
    send_byte(dcs_pkg::CMD_SET_BP);
    send_byte(c);
    send_byte(a[15:8]);
    send_byte(a[7:0]);
  endtask
  // the answer stands for one cycle only: take it at the falling edge that ends the command byte
  task automatic read_reg(input logic [7:0] cmd, output logic [7:0] d, output logic v);
    send_byte(cmd);
    v = rsp_valid;
    d = rsp_byte;
  endtask
  // a deep wake leaves the cpu stopped; halt then resume lets software go on
  task automatic wake_resume();
    send_byte(dcs_pkg::CMD_HALT);
    send_byte(dcs_pkg::CMD_RESUME);
  endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic CLK, RST, CMD_VALID, RSP_VALID, FETCH_VALID, DATA_WR_EN, CPU_CLOCK_GATED;
  logic CRYSTAL_STABLE_FLAG, FAST_RC_STABLE_FLAG, DEBUG_LOCK_FUSE, ERASE_BUSY, DEBUG_ACTIVE;
  logic INJECT_EXEC, STEP_BRANCH, CPU_HALT, TIMERS_STOP, DMA_PAUSE, INFO_REGION_SELECT, REGULATOR_HOLD_ON;
  logic [7:0]  CMD_BYTE, RSP_BYTE, DATA_WR_ADDR;
  logic [17:0] FETCH_ADDR;
  logic [17:0] bpa [4];
  dcs_pkg::dcs_pmode_t POWER_MODE;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  logic exp_halt = 1'h0;
  logic exp_bp = 1'h0;
  logic exp_ovf = 1'h0;

  dcs_debug_ctrl dcs_debug_ctrl_i (.CLK(CLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_BYTE(CMD_BYTE),
    .RSP_VALID(RSP_VALID), .RSP_BYTE(RSP_BYTE), .FETCH_VALID(FETCH_VALID), .FETCH_ADDR(FETCH_ADDR),
    .DATA_WR_EN(DATA_WR_EN), .DATA_WR_ADDR(DATA_WR_ADDR), .CPU_CLOCK_GATED(CPU_CLOCK_GATED),
    .POWER_MODE(POWER_MODE), .CRYSTAL_STABLE_FLAG(CRYSTAL_STABLE_FLAG),
    .FAST_RC_STABLE_FLAG(FAST_RC_STABLE_FLAG), .DEBUG_LOCK_FUSE(DEBUG_LOCK_FUSE), .ERASE_BUSY(ERASE_BUSY),
    .DEBUG_ACTIVE(DEBUG_ACTIVE), .INJECT_EXEC(INJECT_EXEC), .STEP_BRANCH(STEP_BRANCH), .CPU_HALT(CPU_HALT),
    .TIMERS_STOP(TIMERS_STOP), .DMA_PAUSE(DMA_PAUSE), .INFO_REGION_SELECT(INFO_REGION_SELECT),
    .REGULATOR_HOLD_ON(REGULATOR_HOLD_ON));
  dcs_host_model host_i (.clk(CLK), .rsp_valid(RSP_VALID), .rsp_byte(RSP_BYTE), .cmd_valid(CMD_VALID),
    .cmd_byte(CMD_BYTE));

  initial begin
    CLK = 1'h0;
    forever #50 CLK = ~CLK;
  end
  // tests need well under a thousand cycles
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] cmd, input string name, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_i.read_reg(cmd, d, v);
    check("rsp_valid", {7'h0, v}, 8'h01);
    check(name, d, exp);
  endtask
  task automatic chk_status();
    rd(dcs_pkg::CMD_READ_STATUS, "status", {~ERASE_BUSY, CPU_CLOCK_GATED, exp_halt,
      POWER_MODE == dcs_pkg::ACTIVE_POWER_STATE_MODE, exp_bp, DEBUG_LOCK_FUSE,
      CRYSTAL_STABLE_FLAG & FAST_RC_STABLE_FLAG, exp_ovf});
  endtask
  // fetch held two cycles: the first one after a resume is not compared
  task automatic fetch(input logic [17:0] a);
    FETCH_ADDR = a;
    FETCH_VALID = 1'h1;
    repeat (2) @(negedge CLK);
    FETCH_VALID = 1'h0;
    FETCH_ADDR = ~a;
    repeat (2) @(negedge CLK);
  endtask
  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    RST = 1'h1;
    {FETCH_VALID, DATA_WR_EN, CPU_CLOCK_GATED, CRYSTAL_STABLE_FLAG, FAST_RC_STABLE_FLAG} = 5'h00;
    {DEBUG_LOCK_FUSE, ERASE_BUSY, DEBUG_ACTIVE, INJECT_EXEC, STEP_BRANCH} = 5'h00;
    DATA_WR_ADDR = 8'h00;
    FETCH_ADDR = 18'h00000;
    POWER_MODE = dcs_pkg::ACTIVE_POWER_STATE_MODE;
    repeat (10) @(negedge CLK);
    RST = 1'h0;
    check("outs_reset", {4'h0, CPU_HALT, TIMERS_STOP, DMA_PAUSE, INFO_REGION_SELECT}, 8'h00);
    rd(dcs_pkg::CMD_RD_CONFIG, "cfg_reset", dcs_pkg::CFG_RESET);
    for (int i = 0; i < 4; i++) begin
      host_i.write_cfg(4'h1 << i);
      repeat (2) @(negedge CLK);
      rd(dcs_pkg::CMD_RD_CONFIG, "cfg_readback", 8'h01 << i);
      check("cfg_outs", {5'h0, TIMERS_STOP, DMA_PAUSE, INFO_REGION_SELECT},
        {5'h0, i == 3, i == 2, i == 0});
    end
    for (int i = 0; i < 6; i++) begin
      if (i % 3 == 0) host_i.write_cfg(i == 0 ? 4'h2 : 4'h0);
      INJECT_EXEC = (i % 3 == 1);
      STEP_BRANCH = (i % 3 == 2);
      repeat (2) @(negedge CLK);
      check("timer_suspend", {7'h0, TIMERS_STOP}, {7'h0, i < 3 && i % 3 != 0});
    end
    {INJECT_EXEC, STEP_BRANCH} = 2'h0;
    $display("test config done");
    for (int i = 0; i < 2; i++) begin
      {ERASE_BUSY, CPU_CLOCK_GATED, DEBUG_LOCK_FUSE, CRYSTAL_STABLE_FLAG, FAST_RC_STABLE_FLAG} = i ? 5'h03 : 5'h1d;
      DATA_WR_ADDR = i ? dcs_pkg::STACK_TOP_ADDR : 8'hfe;
      DATA_WR_EN = 1'h1;
      @(negedge CLK);
      DATA_WR_EN = 1'h0;
      exp_ovf = (i == 1);
      chk_status();
    end
    $display("test status done");
    host_i.send_byte(dcs_pkg::CMD_RESUME);
    check("resume_running", {7'h0, CPU_HALT}, 8'h00);
    host_i.send_byte(dcs_pkg::CMD_HALT);
    exp_halt = 1'h1;
    check("halt_cmd", {7'h0, CPU_HALT}, 8'h01);
    chk_status();
    host_i.send_byte(dcs_pkg::CMD_RESUME);
    exp_halt = 1'h0;
    check("resume", {7'h0, CPU_HALT}, 8'h00);
    $display("test halt done");
    for (int i = 0; i < 4; i++) begin
      bpa[i] = {i[1:0], 8'ha5, 6'h0f, i[1:0]};
      host_i.set_bp(i[1:0], 1'h1, bpa[i]);
    end
    // last entry written is hit first, so the write-then-hit sequence is exercised
    for (int i = 3; i >= 0; i--) begin
      fetch(bpa[i] ^ 18'h00100);
      check("bp_miss", {7'h0, CPU_HALT}, 8'h00);
      fetch(bpa[i]);
      check("bp_hit", {7'h0, CPU_HALT}, 8'h01);
      {exp_halt, exp_bp} = 2'h3;
      chk_status();
      host_i.send_byte(dcs_pkg::CMD_RESUME);
      exp_halt = 1'h0;
      host_i.set_bp(i[1:0], 1'h0, bpa[i]);
      fetch(bpa[i]);
      check("bp_disabled", {7'h0, CPU_HALT}, 8'h00);
    end
    $display("test breakpoints done");
    DEBUG_ACTIVE = 1'h1;
    POWER_MODE = dcs_pkg::LIGHT_SLEEP_MODE;
    repeat (2) @(negedge CLK);
    check("regulator", {7'h0, REGULATOR_HOLD_ON}, 8'h01);
    chk_status();
    POWER_MODE = dcs_pkg::ACTIVE_POWER_STATE_MODE;
    repeat (3) @(negedge CLK);
    check("light_wake", {7'h0, CPU_HALT}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      POWER_MODE = i ? dcs_pkg::DEEPEST_SLEEP_MODE : dcs_pkg::DEEP_SLEEP_MODE;
      @(negedge CLK);
      POWER_MODE = dcs_pkg::ACTIVE_POWER_STATE_MODE;
      repeat (3) @(negedge CLK);
      check("deep_wake", {7'h0, CPU_HALT}, 8'h01);
      {exp_halt, exp_bp} = 2'h2;
      chk_status();
      host_i.wake_resume();
      exp_halt = 1'h0;
      check("wake_resume", {7'h0, CPU_HALT}, 8'h00);
    end
    $display("test power modes done");
    complete_run();
  end
endmodule
